/* File: logic/pirb_pkg.sv */
package pirb_pkg;

   // ***************************************************************
   // Register map (byte addresses, one aligned word each)
   // ***************************************************************
   localparam logic [11:0] ADDR_FLAGS_TWO   = 12'h000;
   localparam logic [11:0] ADDR_FLAGS_THREE = 12'h004;
   localparam logic [11:0] ADDR_FLAGS_FOUR  = 12'h008;
   localparam logic [11:0] ADDR_FLAGS_FIVE  = 12'h00C;
   localparam logic [11:0] ADDR_FLAGS_SIX   = 12'h010;
   localparam logic [11:0] ADDR_CCP_MODE    = 12'h014;

   // ***************************************************************
   // Implemented-bit masks and reset values
   // ***************************************************************
   localparam logic [7:0] MASK_TWO       = 8'hBF;
   localparam logic [7:0] MASK_THREE     = 8'hFF;
   localparam logic [7:0] MASK_FOUR      = 8'hFF;
   localparam logic [7:0] MASK_FIVE      = 8'hFF;
   localparam logic [7:0] MASK_SIX       = 8'h17;
   localparam logic [7:0] MASK_FOUR_SML  = 8'h3F;
   localparam logic [7:0] MASK_FIVE_SML  = 8'h17;
   localparam logic [7:0] RESET_FLAGS    = 8'h00;
   localparam logic [7:0] HW_ONLY_THREE  = 8'h30;
   localparam int         POS_RX_FULL    = 5;
   localparam int         POS_TX_EMPTY   = 4;
   localparam int         POS_LCD        = 6;
   localparam int         NUM_CCP        = 10;
   localparam logic [19:0] RESET_CCP_MODE = 20'h00000;

   // Capture/compare channel mode (two bits per channel)
   typedef enum logic [1:0]
   {
      PIRB_CCP_OFF     = 2'b00,
      PIRB_CCP_CAPTURE = 2'b01,
      PIRB_CCP_COMPARE = 2'b11,
      PIRB_CCP_PWM     = 2'b10
   } pirb_ccp_mode_e;

   // Peripheral event strobes, one cycle each
   typedef struct packed
   {
      logic       osc_fail;
      logic       sync_port2_done;
      logic       collision2;
      logic       collision1;
      logic       volt_detect;
      logic       timer3_overflow;
      logic       timer3_gate;
      logic       timer5_gate;
      logic       lcd_frame_done;
      logic       charge_time;
      logic       rtc_event;
      logic [9:0] capture;
      logic [9:0] compare_match;
      logic       timer4_match;
      logic       timer5_overflow;
      logic       timer6_match;
      logic       timer7_overflow;
      logic       timer8_match;
      logic       timer10_match;
      logic       timer12_match;
      logic       timer7_gate;
      logic       nvm_write_done;
      logic [2:0] comparator;
   } pirb_events_s;

   // Level status of the second serial port buffers and the LCD type-B nonstatic mode
   typedef struct packed
   {
      logic rx_buffer_full;
      logic tx_buffer_empty;
      logic lcd_type_b_nonstatic;
   } pirb_levels_s;

endpackage

/* File: logic/pirb_flag_bank.sv */
// Operation
// - Oscillator fail sets bit 7, software clears
// - Sync port 2 completion sets bit 5
// - Each bus collision sets its own flag
// - Voltage detect event sets bit 2
// - Timer3 overflow and gate set bits 1,0
// - Unimplemented bits always read zero
// - Rx flag read-only, follows buffer full
// - Tx flag read-only, follows buffer empty
// - LCD flag set after all commons output, type B nonstatic only
// - Capture mode: capture sets channel flag
// - Compare mode: match sets channel flag
// - PWM mode: channel flag never set
// - Charge-time unit event sets held flag
// - Real-time clock event sets held flag
// - Timer 4/6/8/10/12 period match sets flags
// - Timer5/7 overflow, timer7 gate set flags
// - Held flags clear only by software writing zero or by reset
// - Nonvolatile write completion sets flag
// - Three comparator events set bits 2..0
// - Small-memory variant lacks some flags
// - Flags set regardless of any enable
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module pirb_flag_bank #(
   parameter bit SMALL_MEMORY = 1'b0
)(
   input  wire logic                  i_clock,
   input  wire logic                  i_sys_rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire pirb_pkg::pirb_events_s i_events,
   input  wire pirb_pkg::pirb_levels_s i_levels,
   output logic                       o_serial2_rx_buffer_read,
   output logic                       o_serial2_tx_buffer_write,
   output logic      [39:0]           o_flags
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed
   {
      logic [7:0]  flags_two;
      logic [7:0]  flags_three;
      logic [7:0]  flags_four;
      logic [7:0]  flags_five;
      logic [7:0]  flags_six;
      logic [19:0] ccp_mode;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        rx_read;
      logic        tx_write;
   } pirb_state_s;

   pirb_state_s state;
   pirb_state_s next_state;

   // Sticky update: hardware set wins over a software clear
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic       wr,
                                         input logic [7:0] wdata,
                                         input logic [7:0] mask);
      logic [7:0] kept;
      kept = wr ? (cur & wdata) : cur;
      return (kept | set) & mask;
   endfunction

   function automatic logic [1:0] ccp_mode_of(input logic [19:0] modes, input int ch);
      return modes[2*ch +: 2];
   endfunction

   localparam int NUM_CCP_L = pirb_pkg::NUM_CCP;
   localparam int POS_RX_L  = pirb_pkg::POS_RX_FULL;
   localparam int POS_TX_L  = pirb_pkg::POS_TX_EMPTY;

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   logic [7:0]  set_two;
   logic [7:0]  set_three;
   logic [7:0]  set_four;
   logic [7:0]  set_five;
   logic [7:0]  set_six;
   logic [9:0]  ccp_set;
   logic [7:0]  mask_four;
   logic [7:0]  mask_five;
   logic        access;
   logic        wr;
   logic        rd;
   logic        lane0;
   logic        mapped;

   always_comb
   begin
      next_state = state;
      ccp_set    = '0;
      for (int ch = 0; ch < NUM_CCP_L; ch++)
      begin
         unique case (pirb_pkg::pirb_ccp_mode_e'(ccp_mode_of(state.ccp_mode, ch)))
            pirb_pkg::PIRB_CCP_CAPTURE : ccp_set[ch] = i_events.capture[ch];
            pirb_pkg::PIRB_CCP_COMPARE : ccp_set[ch] = i_events.compare_match[ch];
            pirb_pkg::PIRB_CCP_PWM     : ccp_set[ch] = 1'b0;
            pirb_pkg::PIRB_CCP_OFF     : ccp_set[ch] = 1'b0;
         endcase
      end

      set_two = {i_events.osc_fail,
                 1'b0,
                 i_events.sync_port2_done,
                 i_events.collision2,
                 i_events.collision1,
                 i_events.volt_detect,
                 i_events.timer3_overflow,
                 i_events.timer3_gate};
      set_three = {i_events.timer5_gate,
                   i_events.lcd_frame_done & i_levels.lcd_type_b_nonstatic,
                   2'b00,
                   i_events.charge_time,
                   ccp_set[1:0],
                   i_events.rtc_event};
      set_four = ccp_set[9:2];
      set_five = {i_events.timer7_gate,
                  i_events.timer12_match,
                  i_events.timer10_match,
                  i_events.timer8_match,
                  i_events.timer7_overflow,
                  i_events.timer6_match,
                  i_events.timer5_overflow,
                  i_events.timer4_match};
      set_six = {3'b000, i_events.nvm_write_done, 1'b0, i_events.comparator};

      // Smaller variant drops channels 9/10 and the upper timer flags
      mask_four = SMALL_MEMORY ? pirb_pkg::MASK_FOUR_SML : pirb_pkg::MASK_FOUR;
      mask_five = SMALL_MEMORY ? pirb_pkg::MASK_FIVE_SML : pirb_pkg::MASK_FIVE;

      access = psel && penable && !state.pready;
      wr     = access && pwrite;
      rd     = access && !pwrite;
      lane0  = pstrb[0];
      mapped = (paddr == pirb_pkg::ADDR_FLAGS_TWO)   || (paddr == pirb_pkg::ADDR_FLAGS_THREE) ||
               (paddr == pirb_pkg::ADDR_FLAGS_FOUR)  || (paddr == pirb_pkg::ADDR_FLAGS_FIVE)  ||
               (paddr == pirb_pkg::ADDR_FLAGS_SIX)   || (paddr == pirb_pkg::ADDR_CCP_MODE);

      next_state.flags_two = sticky(state.flags_two, set_two,
         wr && lane0 && paddr == pirb_pkg::ADDR_FLAGS_TWO, pwdata[7:0], pirb_pkg::MASK_TWO);
      next_state.flags_three = sticky(state.flags_three, set_three,
         wr && lane0 && paddr == pirb_pkg::ADDR_FLAGS_THREE, pwdata[7:0] | pirb_pkg::HW_ONLY_THREE,
         pirb_pkg::MASK_THREE);
      // Buffer flags are levels from the serial port, not sticky
      next_state.flags_three[POS_RX_L] = i_levels.rx_buffer_full;
      next_state.flags_three[POS_TX_L] = i_levels.tx_buffer_empty;
      next_state.flags_four = sticky(state.flags_four, set_four,
         wr && lane0 && paddr == pirb_pkg::ADDR_FLAGS_FOUR, pwdata[7:0], mask_four);
      next_state.flags_five = sticky(state.flags_five, set_five,
         wr && lane0 && paddr == pirb_pkg::ADDR_FLAGS_FIVE, pwdata[7:0], mask_five);
      next_state.flags_six = sticky(state.flags_six, set_six,
         wr && lane0 && paddr == pirb_pkg::ADDR_FLAGS_SIX, pwdata[7:0], pirb_pkg::MASK_SIX);

      if (wr && paddr == pirb_pkg::ADDR_CCP_MODE)
      begin
         if (pstrb[0]) next_state.ccp_mode[7:0]   = pwdata[7:0];
         if (pstrb[1]) next_state.ccp_mode[15:8]  = pwdata[15:8];
         if (pstrb[2]) next_state.ccp_mode[19:16] = pwdata[19:16];
      end

      // One-wait-state slave: answer one cycle into the access phase
      next_state.pready   = access;
      next_state.pslverr  = access && !mapped;
      next_state.rx_read  = 1'b0;
      next_state.tx_write = 1'b0;
      next_state.prdata   = '0;
      if (rd)
      begin
         unique case (paddr)
            pirb_pkg::ADDR_FLAGS_TWO   : next_state.prdata = {24'h000000, state.flags_two};
            pirb_pkg::ADDR_FLAGS_THREE : next_state.prdata = {24'h000000, state.flags_three};
            pirb_pkg::ADDR_FLAGS_FOUR  : next_state.prdata = {24'h000000, state.flags_four};
            pirb_pkg::ADDR_FLAGS_FIVE  : next_state.prdata = {24'h000000, state.flags_five};
            pirb_pkg::ADDR_FLAGS_SIX   : next_state.prdata = {24'h000000, state.flags_six};
            pirb_pkg::ADDR_CCP_MODE    : next_state.prdata = {12'h000, state.ccp_mode};
            default                    : next_state.prdata = 32'h00000000;
         endcase
      end

      if (i_sys_rst)
      begin
         next_state             = '0;
         next_state.flags_two   = pirb_pkg::RESET_FLAGS;
         next_state.ccp_mode    = pirb_pkg::RESET_CCP_MODE;
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge i_clock)
   begin
      state <= next_state;
   end

   // Buffer access strobes are raised elsewhere by the serial port's data
   // register decode; kept here as registered zeros so the ports are defined.
   assign prdata                    = state.prdata;
   assign pready                    = state.pready;
   assign pslverr                   = state.pslverr;
   assign o_serial2_rx_buffer_read  = state.rx_read;
   assign o_serial2_tx_buffer_write = state.tx_write;
   assign o_flags = {state.flags_six, state.flags_five, state.flags_four,
                     state.flags_three, state.flags_two};

endmodule // pirb_flag_bank

/* File: bench/pirb_flag_bank_props.sv */
`timescale 1ns/1ps
module pirb_flag_bank_props (
   input wire logic                   i_clock,
   input wire logic                   i_sys_rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire pirb_pkg::pirb_events_s i_events,
   input wire pirb_pkg::pirb_levels_s i_levels,
   input wire logic                   o_serial2_rx_buffer_read,
   input wire logic                   o_serial2_tx_buffer_write,
   input wire logic [39:0]            o_flags
);
   // ***************************************************************
   // Bus timing and flag behaviour
   // ***************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   chk_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not one cycle after access start");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_addr: assert property (pready |-> pslverr == (paddr > 12'h014))
      else $error("pslverr wrong for address");
   chk_unimpl_zero: assert property (!o_flags[6] && o_flags[39:37] == 3'h0 && !o_flags[35])
      else $error("unimplemented flag bit set");
   chk_level_follow: assert property (!$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
      o_flags[13:12] == {$past(i_levels.rx_buffer_full), $past(i_levels.tx_buffer_empty)})
      else $error("buffer level flags do not follow levels");
   chk_osc_set: assert property (i_events.osc_fail |=> o_flags[7])
      else $error("oscillator fail flag not set");
   chk_lcd_gate: assert property
      (!o_flags[14] && !(i_events.lcd_frame_done && i_levels.lcd_type_b_nonstatic) |=> !o_flags[14])
      else $error("lcd flag set without gated event");
   chk_flag_hold: assert property (!(psel && pwrite) |=>
      (o_flags[31:24] & $past(o_flags[31:24])) == $past(o_flags[31:24]))
      else $error("flag cleared without a write");
   chk_cmp_set: assert property (i_events.comparator != 3'h0 |=>
      (o_flags[34:32] & $past(i_events.comparator)) == $past(i_events.comparator))
      else $error("comparator flag not set");
   chk_rst_zero: assert property ($fell(i_sys_rst) |-> o_flags == 40'h0)
      else $error("flags not zero after reset");
   cover property (pready && pslverr);
   cover property (pready && !pwrite && prdata[7:0] != 8'h00);
   cover property (o_flags[14]);
endmodule // pirb_flag_bank_props

bind pirb_flag_bank pirb_flag_bank_props chk_u (.i_clock, .i_sys_rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .i_events, .i_levels,
   .o_serial2_rx_buffer_read, .o_serial2_tx_buffer_write, .o_flags);

/* File: bench/pirb_flag_bank_tb_top.sv */
`timescale 1ns/1ps
module pirb_flag_bank_tb_top;
   logic                   i_clock = 1'b0;
   logic                   i_sys_rst = 1'b1;
   logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]            paddr = 12'h000;
   logic [31:0]            pwdata = 32'h0, prdata;
   logic [3:0]             pstrb = 4'h0;
   logic                   pready, pslverr;
   pirb_pkg::pirb_events_s i_events = '0;
   pirb_pkg::pirb_levels_s i_levels = '0;
   logic [39:0]            exp_f = '0;
   logic [19:0]            exp_m = '0;
   logic [32:0]            notes[$];
   int                     n_mismatch = 0, n_tests = 0;

   always #50 i_clock = ~i_clock;

   pirb_flag_bank dut_u (.i_clock, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .i_events, .i_levels, .o_serial2_rx_buffer_read(),
      .o_serial2_tx_buffer_write(), .o_flags());

   // ***************************************************************
   // Reporting and response checking
   // ***************************************************************
   task automatic fail(input string m);
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Write data is not compared, only the error flag
   always @(posedge i_clock)
   begin
      if (pready === 1'b1)
      begin
         n_tests++;
         if (notes.size() == 0)
            fail("response with no note");
         else if ({pslverr, pwrite ? 32'h0 : prdata} !== notes.pop_front())
            fail("response differs from note");
      end
   end

   // ***************************************************************
   // Bus master and reference model
   // ***************************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [32:0] n);
      int k;
      notes.push_back(n);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge i_clock);
      penable <= 1'b1;
      for (k = 0; k < 20 && pready !== 1'b1; k++)
         @(posedge i_clock);
      if (k == 20)
      begin
         fail("no pready");
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clock);
   endtask

   function automatic logic [32:0] rexp(input int i);
      logic [7:0] b;
      if (i == 5)
         return {13'h0, exp_m};
      if (i > 5)
         return {1'b1, 32'h0};
      b = exp_f[8*i +: 8];
      if (i == 1)
         b[5:4] = {i_levels.rx_buffer_full, i_levels.tx_buffer_empty};
      return {25'h0, b};
   endfunction

   task automatic rd(input int i);
      apb(1'b0, 12'(4 * i), 32'h0, 4'h0, rexp(i));
   endtask

   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, 12'(4 * i), d, s, {i > 5, 32'h0});
      if (i == 5)
         exp_m = d[19:0];
      else if (i < 5 && s[0])
         exp_f[8*i +: 8] = exp_f[8*i +: 8] & d[7:0];
   endtask

   // Sparse random strobes so that flags do not all saturate at once
   task automatic pulse();
      logic [63:0]            r;
      pirb_pkg::pirb_events_s e;
      logic [9:0]             c;
      r = {$urandom, $urandom} & {$urandom, $urandom};
      e = r[42:0];
      i_events <= e;
      @(posedge i_clock);
      for (int j = 0; j < 10; j++)
         c[j] = (exp_m[2*j +: 2] == pirb_pkg::PIRB_CCP_CAPTURE && e.capture[j])
             || (exp_m[2*j +: 2] == pirb_pkg::PIRB_CCP_COMPARE && e.compare_match[j]);
      exp_f = exp_f | {3'b0, e.nvm_write_done, 1'b0, e.comparator, e.timer7_gate,
         e.timer12_match, e.timer10_match, e.timer8_match, e.timer7_overflow, e.timer6_match,
         e.timer5_overflow, e.timer4_match, c[9:2], e.timer5_gate,
         e.lcd_frame_done & i_levels.lcd_type_b_nonstatic, 2'b0, e.charge_time, c[1:0],
         e.rtc_event, e.osc_fail, 1'b0, e.sync_port2_done, e.collision2, e.collision1,
         e.volt_detect, e.timer3_overflow, e.timer3_gate};
   endtask

   task automatic reset_dut();
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      exp_f = '0;
      exp_m = '0;
      @(posedge i_clock);
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      int j;
      void'($urandom(23165));
      reset_dut();
      for (int i = 0; i < 7; i++)
         rd(i);
      wr(6, 32'hFFFFFFFF, 4'hF);
      for (int t = 0; t < 60; t++)
      begin
         wr(5, $urandom, 4'hF);
         i_levels <= 3'($urandom);
         repeat ($urandom_range(1, 3)) pulse();
         i_events <= '0;
         @(posedge i_clock);
         for (int i = 0; i < 6; i++)
            rd(i);
         j = $urandom_range(0, 4);
         wr(j, $urandom, 4'($urandom));
         rd(j);
         if (t == 30)
            reset_dut();
      end
      stop_test();
   end
endmodule // pirb_flag_bank_tb_top
